// ### hw/ualt_ctrl.sv
/*
 * ULPI alternate-mode controller: register access over ULPI, carkit
 * (UART/audio) and headset audio pin remapping, ID resistance converter
 * and RXCMD event reporting through a small queue.
 * Assumes ULPI inputs synchronous to ref_clk and rstn from the reset pin.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Clock output stops in carkit mode unless keep-clock bit was set beforehand.
// - Carkit interrupt only from sources enabled in carkit interrupt enable.
// - Sample sources in the same cycle DIR rises; flag when live level differs.
// - No line state presented to the Link in carkit mode.
// - STP exits mode; DIR drops, then wait STP low before sync operation.
// - Reset pin low resets everything and returns to sync mode.
// - UART: data bit 0 goes to DM, DP level returns on data bit 1.
// - UART entry applies regulator level field and DP/DM pull-ups.
// - UART edge rates follow transceiver-speed select field.
// - Carkit: data 2 and 4-7 low, data 3 high on pending interrupt.
// - Sync mode: audio switches follow register write immediately.
// - ID-ground fall: RXCMD bit 6 low in sync, data 3 high in carkit, data 4 low in headset.
// - Start bit launches ID measurement; it clears when done.
// - With measure irq enabled, completion sends RXCMD with alt bit.
// - Completion loads the measured code into the value field.
// - Headset register write enters headset mode without touching audio switches.
// - Headset: d0 session, d1 gated vbus, d3 low, d4 ground, d5 float.
// - Headset inputs: d2 grounds ID, d6 high-ohm pull-up, d7 low-ohm pull-up.
module ualt_ctrl #(
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // ULPI link
   input wire logic stp,
   input wire logic [7:0] data_i,
   output logic dir,
   output logic nxt,
   output logic [7:0] data_o,
   output logic [7:0] data_oe_n,
   // Analog status
   input wire logic id_grounded_comparator,
   input wire logic id_float_cmp,
   input wire logic vbus_valid_cmp,
   input wire logic sess_valid_cmp,
   input wire logic dp_rx_level,
   input wire logic [1:0] line_state,
   input wire logic [2:0] id_adc_code,
   // Analog controls
   output logic clock_output_run,
   output logic dm_tx_level,
   output logic uart_pullups_en,
   output logic uart_regulator_level,
   output logic tx_low_speed_edges,
   output logic left_audio_switch_en,
   output logic right_audio_switch_en,
   output logic id_force_ground,
   output logic id_high_ohm_pullup_en,
   output logic id_low_ohm_pullup_en
);
   ualt_pkg::ualt_state_t st_q;
   logic dir_q, nxt_q, clk_run_q, dm_q, pu_q, lvl_q, ls_q, left_q, right_q;
   logic idg_q, idh_q, idl_q;
   logic [7:0] do_q, oe_n_q;
   logic [7:0] func_q, ifc_q, carkit_q, cie_q, headset_q, rid_q, iopwr_q;
   logic [5:0] addr_q;
   logic [3:0] src, sampled_q;
   logic id_prev_q, idfall_pend_q, rid_pend_q, rid_run_q, rid_done;
   logic [15:0] rid_cnt_q;
   logic wr_en, exit_clr, alt_irq, sync_mode, uart_on;
   logic [7:0] rd_val;

   ualt_stream_if #(.WIDTH(8)) q_in ();
   ualt_stream_if #(.WIDTH(8)) q_out ();

   ualt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst_n(rstn),
      .wr(q_in.snk),
      .rd(q_out.src)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register helpers: base, base+1 set, base+2 clear
   function automatic logic hit3(input logic [5:0] a, input logic [5:0] b);
      hit3 = (a >= b) && (a <= b + 6'h2);
   endfunction : hit3

   function automatic logic [7:0] upd(input logic [7:0] cur, input logic [5:0] a, input logic [5:0] b,
                                      input logic [7:0] v);
      logic [1:0] op;
      op = 2'(a - b);
      unique case (op)
         2'h1: upd = cur | v;
         2'h2: upd = cur & ~v;
         default: upd = v;
      endcase
   endfunction : upd
   // Outputs straight from flops
   assign {dir, nxt, data_o, data_oe_n} = {dir_q, nxt_q, do_q, oe_n_q};
   assign {clock_output_run, dm_tx_level, uart_pullups_en, uart_regulator_level} = {clk_run_q, dm_q, pu_q, lvl_q};
   assign {tx_low_speed_edges, left_audio_switch_en, right_audio_switch_en} = {ls_q, left_q, right_q};
   assign {id_force_ground, id_high_ohm_pullup_en, id_low_ohm_pullup_en} = {idg_q, idh_q, idl_q};
   ////////////////////////////////////////////////////////////////////////
   // Decode of current activity
   assign wr_en = (st_q == ualt_pkg::ST_W_DATA);
   assign exit_clr = ((st_q == ualt_pkg::ST_CARKIT) || (st_q == ualt_pkg::ST_HEADSET)) && stp;
   assign sync_mode = (st_q != ualt_pkg::ST_CARKIT) && (st_q != ualt_pkg::ST_HEADSET)
                      && (st_q != ualt_pkg::ST_ENTER);
   assign uart_on = (st_q == ualt_pkg::ST_CARKIT) && carkit_q[ualt_pkg::CK_TX_ROUTE]
                    && carkit_q[ualt_pkg::CK_RX_ROUTE];
   assign src = {sess_valid_cmp, vbus_valid_cmp, id_grounded_comparator, id_float_cmp};
   // Only enabled sources whose level moved since entry
   assign alt_irq = |((src ^ sampled_q) & cie_q[3:0]);

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rd_val = 8'h00;
      if (hit3(addr_q, ualt_pkg::A_FUNC)) rd_val = func_q;
      else if (hit3(addr_q, ualt_pkg::A_IFC)) rd_val = ifc_q;
      else if (hit3(addr_q, ualt_pkg::A_CARKIT)) rd_val = carkit_q;
      else if (hit3(addr_q, ualt_pkg::A_CIE)) rd_val = cie_q;
      else if (addr_q == ualt_pkg::A_HEADSET) rd_val = headset_q;
      else if (hit3(addr_q, ualt_pkg::A_RID)) rd_val = rid_q;
      else if (hit3(addr_q, ualt_pkg::A_IOPWR)) rd_val = iopwr_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Plain read/write/set/clear registers
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         func_q <= ualt_pkg::R_FUNC;
         carkit_q <= ualt_pkg::R_CARKIT;
         cie_q <= ualt_pkg::R_CIE;
         iopwr_q <= ualt_pkg::R_IOPWR;
      end
      else if (wr_en)
      begin
         if (hit3(addr_q, ualt_pkg::A_FUNC))
            func_q <= upd(func_q, addr_q, ualt_pkg::A_FUNC, data_i) & ualt_pkg::FUNC_WMASK;
         if (hit3(addr_q, ualt_pkg::A_CARKIT))
            carkit_q <= upd(carkit_q, addr_q, ualt_pkg::A_CARKIT, data_i);
         if (hit3(addr_q, ualt_pkg::A_CIE))
            cie_q <= upd(cie_q, addr_q, ualt_pkg::A_CIE, data_i);
         if (hit3(addr_q, ualt_pkg::A_IOPWR))
            iopwr_q <= upd(iopwr_q, addr_q, ualt_pkg::A_IOPWR, data_i);
      end
   end

   // Mode registers; hardware clears the mode on exit
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ifc_q <= ualt_pkg::R_IFC;
         headset_q <= ualt_pkg::R_HEADSET;
      end
      else if (exit_clr)
      begin
         ifc_q[ualt_pkg::IFC_ACCESSORY] <= 1'b0;
         headset_q[ualt_pkg::HS_MODE] <= 1'b0;
      end
      else if (wr_en)
      begin
         if (hit3(addr_q, ualt_pkg::A_IFC))
            ifc_q <= upd(ifc_q, addr_q, ualt_pkg::A_IFC, data_i);
         if (addr_q == ualt_pkg::A_HEADSET)
            headset_q <= data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ID resistance converter; completion beats a same-cycle write
   assign rid_done = rid_run_q && (rid_cnt_q == 16'h0000);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rid_q <= ualt_pkg::R_RID;
         rid_run_q <= 1'b0;
         rid_cnt_q <= 16'h0000;
      end
      else
      begin
         if (wr_en && hit3(addr_q, ualt_pkg::A_RID))
            rid_q <= upd(rid_q, addr_q, ualt_pkg::A_RID, data_i);
         if (rid_done)
         begin
            rid_run_q <= 1'b0;
            rid_q[ualt_pkg::RID_START] <= 1'b0;
            rid_q[2:0] <= id_adc_code;
         end
         else if (rid_run_q)
            rid_cnt_q <= rid_cnt_q - 16'h0001;
         else if (rid_q[ualt_pkg::RID_START])
         begin
            rid_run_q <= 1'b1;
            rid_cnt_q <= ualt_pkg::RID_CONV_LOAD;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // RXCMD events: pending until the queue takes them, set beats clear
   assign q_in.valid = idfall_pend_q | rid_pend_q;
   assign q_in.data = {rid_pend_q, id_grounded_comparator, 2'h0,
                       vbus_valid_cmp, sess_valid_cmp, line_state};
   assign q_out.ready = (st_q == ualt_pkg::ST_X_TURN);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         id_prev_q <= 1'b1;
         idfall_pend_q <= 1'b0;
         rid_pend_q <= 1'b0;
      end
      else
      begin
         id_prev_q <= id_grounded_comparator;
         if (sync_mode && id_prev_q && !id_grounded_comparator)
            idfall_pend_q <= 1'b1;
         else if (q_in.ready)
            idfall_pend_q <= 1'b0;
         if (rid_done && rid_q[ualt_pkg::RID_IRQ_EN])
            rid_pend_q <= 1'b1;
         else if (q_in.ready)
            rid_pend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ULPI sequencer and pin drive
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q <= ualt_pkg::ST_IDLE;
         dir_q <= 1'b0;
         nxt_q <= 1'b0;
         do_q <= 8'h00;
         oe_n_q <= 8'hff;
         addr_q <= 6'h00;
         sampled_q <= 4'h0;
         clk_run_q <= 1'b1;
      end
      else if (exit_clr)
      begin
         // Leave carkit or headset on STP; pins released first
         do_q <= 8'h00;
         oe_n_q <= 8'hff;
         dir_q <= 1'b0;
         clk_run_q <= 1'b1;
         st_q <= ualt_pkg::ST_EXIT;
      end
      else
      begin
         unique case (st_q)
            ualt_pkg::ST_IDLE:
            begin
               // Bit 6 tells a read command from a write
               if (data_i[7:6] == ualt_pkg::TX_WRITE || data_i[7:6] == ualt_pkg::TX_READ)
               begin
                  addr_q <= data_i[5:0];
                  nxt_q <= 1'b1;
                  st_q <= data_i[6] ? ualt_pkg::ST_R_NXT : ualt_pkg::ST_W_NXT;
               end
               else if (q_out.valid)
               begin
                  dir_q <= 1'b1;
                  st_q <= ualt_pkg::ST_X_TURN;
               end
            end
            ualt_pkg::ST_W_NXT:
            begin
               nxt_q <= 1'b0;
               st_q <= ualt_pkg::ST_W_DATA;
            end
            ualt_pkg::ST_W_DATA:
               st_q <= ualt_pkg::ST_W_STP;
            ualt_pkg::ST_W_STP:
            begin
               // Mode bits were written the cycle before; enter on STP
               if (stp && (ifc_q[ualt_pkg::IFC_ACCESSORY] || headset_q[ualt_pkg::HS_MODE]))
                  st_q <= ualt_pkg::ST_ENTER;
               else if (stp)
                  st_q <= ualt_pkg::ST_IDLE;
            end
            ualt_pkg::ST_R_NXT:
            begin
               nxt_q <= 1'b0;
               dir_q <= 1'b1;
               st_q <= ualt_pkg::ST_R_TURN;
            end
            ualt_pkg::ST_R_TURN:
            begin
               do_q <= rd_val;
               oe_n_q <= 8'h00;
               st_q <= ualt_pkg::ST_R_DATA;
            end
            ualt_pkg::ST_X_TURN:
            begin
               do_q <= q_out.data;
               oe_n_q <= 8'h00;
               st_q <= ualt_pkg::ST_X_DATA;
            end
            ualt_pkg::ST_R_DATA, ualt_pkg::ST_X_DATA:
            begin
               dir_q <= 1'b0;
               oe_n_q <= 8'hff;
               st_q <= ualt_pkg::ST_IDLE;
            end
            ualt_pkg::ST_ENTER:
            begin
               sampled_q <= src;
               dir_q <= 1'b1;
               clk_run_q <= ifc_q[ualt_pkg::IFC_KEEP_CLK];
               st_q <= headset_q[ualt_pkg::HS_MODE] ? ualt_pkg::ST_HEADSET : ualt_pkg::ST_CARKIT;
            end
            ualt_pkg::ST_CARKIT:
            begin
               // Bit 0 is link input; no line state is ever driven here
               do_q <= {4'h0, alt_irq, 1'b0,
                        carkit_q[ualt_pkg::CK_RX_ROUTE] & dp_rx_level, 1'b0};
               oe_n_q <= 8'h01;
            end
            ualt_pkg::ST_HEADSET:
            begin
               do_q <= {2'h0, id_float_cmp, id_grounded_comparator, 1'b0, 1'b0,
                        vbus_valid_cmp & cie_q[ualt_pkg::CIE_VBUS], sess_valid_cmp};
               oe_n_q <= 8'hc4;
            end
            ualt_pkg::ST_EXIT:
            begin
               if (!stp)
                  st_q <= ualt_pkg::ST_IDLE;
            end
            default:
               st_q <= ualt_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog controls; audio switches only move in sync mode so alt
   // modes never glitch the audio path
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dm_q <= 1'b1;
         pu_q <= 1'b0;
         lvl_q <= 1'b0;
         ls_q <= 1'b0;
         left_q <= 1'b0;
         right_q <= 1'b0;
         idg_q <= 1'b0;
         idh_q <= 1'b0;
         idl_q <= 1'b0;
      end
      else
      begin
         dm_q <= uart_on ? data_i[0] : 1'b1;
         pu_q <= uart_on;
         lvl_q <= iopwr_q[ualt_pkg::IOPWR_UART_LVL];
         ls_q <= (func_q[1:0] == ualt_pkg::XCVR_LS);
         if (sync_mode)
         begin
            left_q <= carkit_q[ualt_pkg::CK_LEFT];
            right_q <= carkit_q[ualt_pkg::CK_RIGHT];
         end
         {idl_q, idh_q, idg_q} <= {3{st_q == ualt_pkg::ST_HEADSET}} & {data_i[7], data_i[6], data_i[2]};
      end
   end
endmodule : ualt_ctrl
`default_nettype wire

// ### hw/ualt_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock.
 */
`timescale 1ns/100ps
`default_nettype none
module ualt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Streams
   ualt_stream_if.snk wr,
   ualt_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes; full refuses the writer, empty starves the reader
   assign wr.ready = (cnt_q != FULL);
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem[rp_q];
   assign push = wr.valid & wr.ready;
   assign pop = rd.valid & rd.ready;

   // Storage, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wp_q] <= wr.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop)
         begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : ualt_fifo
`default_nettype wire

// ### hw/ualt_pkg.sv
/*
 * Shared constants for the ULPI alternate-mode controller: register
 * addresses, reset values, field positions, timing and state codes.
 * Assumes a 100 MHz single clock domain.
 */
package ualt_pkg;
   // Clock and converter timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned RID_CONV_TIME_NS = 2000;
   localparam int unsigned RID_CONV_CYCLES = (RID_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] RID_CONV_LOAD = 16'(RID_CONV_CYCLES - 1);

   // Register base addresses (write; set at +1, clear at +2; headset has no set or clear)
   localparam logic [5:0] A_FUNC = 6'h04;
   localparam logic [5:0] A_IFC = 6'h07;
   localparam logic [5:0] A_CARKIT = 6'h19;
   localparam logic [5:0] A_CIE = 6'h1d;
   localparam logic [5:0] A_HEADSET = 6'h33;
   localparam logic [5:0] A_RID = 6'h36;
   localparam logic [5:0] A_IOPWR = 6'h39;

   // Reset values
   localparam logic [7:0] R_FUNC = 8'h41;
   localparam logic [7:0] R_IFC = 8'h00;
   localparam logic [7:0] R_CARKIT = 8'h00;
   localparam logic [7:0] R_CIE = 8'h00;
   localparam logic [7:0] R_HEADSET = 8'h00;
   localparam logic [7:0] R_RID = 8'h00;
   localparam logic [7:0] R_IOPWR = 8'h04;
   localparam logic [7:0] FUNC_WMASK = 8'h7f;

   // Field positions
   localparam int IFC_ACCESSORY = 2;
   localparam int IFC_KEEP_CLK = 3;
   localparam int CK_TX_ROUTE = 2;
   localparam int CK_RX_ROUTE = 3;
   localparam int CK_LEFT = 4;
   localparam int CK_RIGHT = 5;
   localparam int HS_MODE = 0;
   localparam int RID_IRQ_EN = 5;
   localparam int RID_START = 6;
   localparam int IOPWR_UART_LVL = 1;
   localparam int CIE_VBUS = 2;
   localparam int RX_ID = 6;
   localparam int RX_ALT = 7;
   localparam logic [1:0] XCVR_LS = 2'h2;

   // Link command prefixes
   localparam logic [1:0] TX_WRITE = 2'h2;
   localparam logic [1:0] TX_READ = 2'h3;

   // Interface sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_W_NXT = 4'h1,
      ST_W_DATA = 4'h2,
      ST_W_STP = 4'h3,
      ST_R_NXT = 4'h4,
      ST_R_TURN = 4'h5,
      ST_R_DATA = 4'h6,
      ST_X_TURN = 4'h7,
      ST_X_DATA = 4'h8,
      ST_ENTER = 4'h9,
      ST_CARKIT = 4'ha,
      ST_HEADSET = 4'hb,
      ST_EXIT = 4'hc
   } ualt_state_t;
endpackage : ualt_pkg

// ### hw/ualt_stream_if.sv
/*
 * Valid/ready byte stream between the controller and its queue.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface ualt_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : ualt_stream_if
`default_nettype wire

// ### tb/test_ulpi_alt_mode_control.sv
/*
 * Bench for the alternate-mode controller: registers, carkit, headset, ID events, reset.
 * Assumes the link model drives stp and the link share of the data lines.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_ulpi_alt_mode_control;
   logic ref_clk, rstn, stp, dir, nxt, idg, idf, vbv, ssv, dpr, clk_run, dm_tx, pu, lvl, lse, lft, rgt, ifg, ihi, ilo;
   logic [7:0] data_i, data_o, oe_n, v;
   logic [1:0] ls;
   logic [2:0] code;
   int n_errors = 0;
   int compares = 0;
   logic [5:0] ra [8] = '{6'h04, 6'h07, 6'h19, 6'h1d, 6'h33, 6'h36, 6'h39, 6'h3f};
   logic [7:0] rv [8] = '{8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
   ualt_ctrl #(.FIFO_DEPTH(4)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .stp(stp), .data_i(data_i), .dir(dir),
      .nxt(nxt), .data_o(data_o), .data_oe_n(oe_n), .id_grounded_comparator(idg), .id_float_cmp(idf),
      .vbus_valid_cmp(vbv), .sess_valid_cmp(ssv), .dp_rx_level(dpr), .line_state(ls), .id_adc_code(code),
      .clock_output_run(clk_run), .dm_tx_level(dm_tx), .uart_pullups_en(pu), .uart_regulator_level(lvl),
      .tx_low_speed_edges(lse), .left_audio_switch_en(lft), .right_audio_switch_en(rgt),
      .id_force_ground(ifg), .id_high_ohm_pullup_en(ihi), .id_low_ohm_pullup_en(ilo));
   ualt_link_model i_link (.clk(ref_clk), .dir(dir), .nxt(nxt), .data_o(data_o), .data_oe_n(oe_n),
      .stp(stp), .data_i(data_i));
   initial
   begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : cyc
   task automatic stop_test;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard, well past the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end
   initial
   begin
      {rstn, idf, vbv, ssv} = 4'h0;
      {idg, dpr} = 2'h3;
      ls = 2'h1;
      code = 3'h5;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'h1;
      foreach (ra[i])
      begin
         i_link.rd(ra[i], v);
         `CHK("reset value", rv[i], v)
      end
      // Set and clear aliases, switches follow at once in sync mode
      i_link.wr(6'h1a, 8'h30);
      cyc(1);
      `CHK("audio on", 2'h3, {lft, rgt})
      i_link.rd(6'h19, v);
      `CHK("set alias", 8'h30, v)
      i_link.wr(6'h1b, 8'h30);
      cyc(1);
      `CHK("audio off", 2'h0, {lft, rgt})
      // UART entry, routes before the mode bit
      i_link.wr(6'h04, 8'h49);
      i_link.wr(6'h39, 8'h00);
      i_link.wr(6'h19, 8'h0c);
      i_link.wr(6'h07, 8'h04);
      i_link.wt(1'h1, 1'h0, 20);
      @(posedge ref_clk) i_link.drv <= 8'h01;
      cyc(2);
      `CHK("carkit pins", 7'h01, data_i[7:1])
      `CHK("uart analog", 5'h09, {clk_run, pu, lvl, lse, dm_tx})
      @(posedge ref_clk) i_link.drv <= 8'h00;
      dpr <= 1'h0;
      idf <= 1'h1;
      cyc(2);
      `CHK("uart lines", 8'h00, {data_i[7:1], dm_tx})
      i_link.ex();
      `CHK("exit", 2'h1, {dir, clk_run})
      i_link.rd(6'h07, v);
      `CHK("mode cleared", 8'h00, v)
      // Second entry: keep clock, slow edges, one unmasked source
      i_link.wr(6'h04, 8'h4a);
      i_link.wr(6'h39, 8'h02);
      i_link.wr(6'h1d, 8'h01);
      i_link.wr(6'h19, 8'h0c);
      i_link.wr(6'h07, 8'h0c);
      i_link.wt(1'h1, 1'h0, 20);
      @(posedge ref_clk) i_link.drv <= 8'h01;
      cyc(2);
      `CHK("keep clock", 4'hf, {clk_run, pu, lvl, lse})
      @(posedge ref_clk) idf <= 1'h0;
      cyc(2);
      `CHK("irq up", 7'h04, data_i[7:1])
      @(posedge ref_clk) idf <= 1'h1;
      cyc(2);
      `CHK("irq down", 7'h00, data_i[7:1])
      i_link.ex();
      // Headset mode over an active audio path
      i_link.wr(6'h19, 8'h30);
      i_link.wr(6'h33, 8'h01);
      i_link.wt(1'h1, 1'h0, 20);
      @(posedge ref_clk) ssv <= 1'h1;
      vbv <= 1'h1;
      cyc(2);
      `CHK("headset pins", 8'h31, data_i)
      `CHK("switches kept", 2'h3, {lft, rgt})
      @(posedge ref_clk) i_link.drv <= 8'hc4;
      cyc(2);
      `CHK("id controls", 3'h7, {ifg, ihi, ilo})
      i_link.ex();
      i_link.rd(6'h33, v);
      `CHK("headset cleared", 8'h00, v)
      // Events reported in sync mode
      @(posedge ref_clk) idg <= 1'h0;
      i_link.rx(v, 20);
      `CHK("id fall event", 8'h0d, v)
      i_link.wr(6'h36, 8'h60);
      i_link.rx(v, 400);
      `CHK("measure event", 8'h8d, v)
      i_link.rd(6'h36, v);
      `CHK("measure result", 8'h25, v)
      // Reset pin pulled in the middle of carkit mode
      i_link.wr(6'h07, 8'h04);
      i_link.wt(1'h1, 1'h0, 20);
      @(posedge ref_clk) rstn <= 1'h0;
      cyc(2);
      `CHK("reset exits", 10'h1ff, {dir, oe_n, clk_run})
      @(posedge ref_clk) rstn <= 1'h1;
      i_link.rd(6'h07, v);
      `CHK("reset regs", 8'h00, v)
      stop_test();
   end
endmodule : test_ulpi_alt_mode_control
`default_nettype wire

// ### tb/ualt_chk.sv
/*
 * Concurrent checks on the ports of the alternate-mode controller.
 * Assumes one clock domain and the pin maps of the carkit and headset modes.
 */
`timescale 1ns/100ps
`default_nettype none
module ualt_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Link bus
   input wire logic stp,
   input wire logic [7:0] data_i,
   input wire logic dir,
   input wire logic nxt,
   input wire logic [7:0] data_o,
   input wire logic [7:0] data_oe_n,
   // Analog side
   input wire logic id_grounded_comparator,
   input wire logic id_float_cmp,
   input wire logic vbus_valid_cmp,
   input wire logic sess_valid_cmp,
   input wire logic dp_rx_level,
   input wire logic clock_output_run,
   input wire logic dm_tx_level,
   input wire logic uart_pullups_en,
   input wire logic id_force_ground
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic ck;
   logic hs;
   // Mode decode from dir and the pin enables
   assign ck = dir && data_oe_n == 8'h01;
   assign hs = dir && data_oe_n == 8'hc4;
   ////////////////////////////////////////////////////////////////////////////
   property p_ck_fixed;
      ck |-> data_o[7:4] == 4'h0 && !data_o[2];
   endproperty
   a_ck_fixed: assert property (p_ck_fixed)
      else $error("carkit reserved pins not low");
   property p_ck_rxd;
      ck && $past(ck) && uart_pullups_en |-> data_o[1] == $past(dp_rx_level);
   endproperty
   a_ck_rxd: assert property (p_ck_rxd)
      else $error("receive level not returned");
   property p_ck_txd;
      ck && $past(ck) && $past(uart_pullups_en) |-> dm_tx_level == $past(data_i[0]);
   endproperty
   a_ck_txd: assert property (p_ck_txd)
      else $error("transmit level not forwarded");
   property p_hs_status;
      hs && $past(hs) |-> data_o[5:3] == {$past(id_float_cmp), $past(id_grounded_comparator), 1'h0}
         && data_o[0] == $past(sess_valid_cmp);
   endproperty
   a_hs_status: assert property (p_hs_status)
      else $error("headset status pins wrong");
   property p_hs_vbus;
      hs && data_o[1] |-> $past(vbus_valid_cmp);
   endproperty
   a_hs_vbus: assert property (p_hs_vbus)
      else $error("vbus pin high without comparator");
   property p_hs_drive;
      hs && $past(hs) |-> id_force_ground == $past(data_i[2]);
   endproperty
   a_hs_drive: assert property (p_hs_drive)
      else $error("id ground drive not following link");
   property p_exit;
      (ck || hs) && stp |=> !dir && data_oe_n == 8'hff && clock_output_run;
   endproperty
   a_exit: assert property (p_exit)
      else $error("alternate mode not left on stop");
   property p_read_walk;
      nxt && !dir && $past(data_i[7:6]) == 2'h3 |=> dir ##1 (dir && data_oe_n == 8'h00)
         ##1 (!dir && data_oe_n == 8'hff);
   endproperty
   a_read_walk: assert property (p_read_walk)
      else $error("register read turnaround wrong");
endmodule : ualt_chk
bind ualt_ctrl ualt_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .stp(stp), .data_i(data_i), .dir(dir),
   .nxt(nxt), .data_o(data_o), .data_oe_n(data_oe_n), .id_grounded_comparator(id_grounded_comparator),
   .id_float_cmp(id_float_cmp), .vbus_valid_cmp(vbus_valid_cmp), .sess_valid_cmp(sess_valid_cmp),
   .dp_rx_level(dp_rx_level), .clock_output_run(clock_output_run), .dm_tx_level(dm_tx_level),
   .uart_pullups_en(uart_pullups_en), .id_force_ground(id_force_ground));
`default_nettype wire

// ### tb/ualt_link_model.sv
/*
 * Link-side model: owns stp and the link share of the data lines.
 * Assumes the device drives a bit only while its enable is low; released bits read the link drive.
 */
`timescale 1ns/100ps
`default_nettype none
module ualt_link_model (
   // Clock
   input wire logic clk,
   // Device side
   input wire logic dir,
   input wire logic nxt,
   input wire logic [7:0] data_o,
   input wire logic [7:0] data_oe_n,
   // Link side
   output logic stp,
   output logic [7:0] data_i
);
   logic [7:0] drv = 8'h00;
   initial stp = 1'h0;
   // Device wins where it drives, link drive elsewhere
   assign data_i = (data_o & ~data_oe_n) | (drv & data_oe_n);
   // Bounded wait so a dead device cannot hang the run
   task automatic wt(input logic lvl, input bit on_nxt, input int lim);
      int n;
      n = 0;
      do @(negedge clk); while (((on_nxt ? nxt : dir) !== lvl) && ++n < lim);
   endtask : wt
   // Command held until nxt, then one data byte, then stp
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk) drv <= {2'h2, a};
      wt(1'h1, 1'h1, 20);
      @(posedge clk) drv <= d;
      @(posedge clk);
      drv <= 8'h00;
      stp <= 1'h1;
      @(posedge clk) stp <= 1'h0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk) drv <= {2'h3, a};
      wt(1'h1, 1'h1, 20);
      @(posedge clk) drv <= 8'h00;
      rx(d, 20);
   endtask : rd
   task automatic rx(output logic [7:0] d, input int lim);
      wt(1'h1, 1'h0, lim);
      @(negedge clk) d = data_i;
      wt(1'h0, 1'h0, 20);
   endtask : rx
   // Stop held until the device lets go of dir
   task automatic ex;
      @(posedge clk);
      drv <= 8'h00;
      stp <= 1'h1;
      wt(1'h0, 1'h0, 20);
      @(posedge clk) stp <= 1'h0;
   endtask : ex
endmodule : ualt_link_model
`default_nettype wire
